// [rtl/regbridge_pkg.sv]
package regbridge_pkg;

  // ==========================================================
  // Value map elements
  localparam logic [11:0] PAGE_ELEM = 12'h800;
  localparam logic [11:0] USER_BASE = 12'ha00;
  localparam logic [11:0] USER_LAST = 12'hbfe;

  // ==========================================================
  // Message field codes
  localparam logic ACC_BYTE = 1'b1;
  localparam logic [2:0] SLICE_2B = 3'h1;
  localparam logic [7:0] MGR_LA = 8'hff;

  // ==========================================================
  // Reset values and address layout
  localparam logic [15:0] PAGE_RST = 16'h0000;
  localparam logic [15:0] TID_RST = 16'h0000;
  localparam int LO_MSB = 8;
  localparam int LO_LSB = 1;

  typedef enum logic {
    MSG_CHANGE = 1'b0,
    MSG_REQUEST = 1'b1
  } msg_kind_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic wr;
    logic [15:0] tid;
    logic [7:0] src;
  } acc_t;

endpackage : regbridge_pkg

// [rtl/msg_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface msg_link_if
  import regbridge_pkg::*;
(
  input wire logic link_clk
);
  // Manager to device messages
  logic m_valid;
  msg_kind_t m_kind;
  logic [7:0] m_src;
  logic [7:0] m_dst;
  logic m_mode;
  logic [11:0] m_elem;
  logic [2:0] m_slice;
  logic [15:0] m_value;
  // Device replies
  logic r_valid;
  logic [7:0] r_src;
  logic [7:0] r_dst;
  logic [15:0] r_tid;
  logic [15:0] r_value;

  modport mgr (
    input link_clk,
    output m_valid, m_kind, m_src, m_dst, m_mode, m_elem, m_slice, m_value,
    input r_valid, r_src, r_dst, r_tid, r_value
  );
  modport dev (
    input link_clk,
    input m_valid, m_kind, m_src, m_dst, m_mode, m_elem, m_slice, m_value,
    output r_valid, r_src, r_dst, r_tid, r_value
  );
endinterface : msg_link_if
`default_nettype wire

// [rtl/sync3.sv]
`timescale 1ns/10ps
`default_nettype none
module sync3 (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Level in, filtered level out
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sync_t;

  sync_t st_q;
  sync_t st_d;

  // Change taken only once second and third stages agree
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3)
    begin
      st_d.q = st_q.s3;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign q = st_q.q;
endmodule : sync3
`default_nettype wire

// [rtl/dev_bridge.sv]
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Read and write every register via value map
// - Change to page element loads page bits 23:8
// - Change to user element writes page plus byte
// - Page kept across accesses; page message optional
// - Sender uses byte access mode
// - Sender uses two-byte slice size
// - Act only on own logical address
// - Accept any source logical address
// - Request to user element reads, carries ID
// - Answer serviced read with reply message
// - Manager leaves slots for reply first
// - Manager should await reply before next request
// - Newer read drops earlier pending reads
// - Shares interface identity with audio ports
module dev_bridge
  import regbridge_pkg::*;
(
  // Link side
  msg_link_if.dev link,
  // Own logical address, static while link is active
  input wire logic [7:0] dev_la,
  // Register side clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Internal register bus
  output logic reg_req,
  output logic reg_we,
  output logic [23:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic [15:0] reg_rdata
);

  // ==========================================================
  // Link domain state
  typedef struct packed {
    logic [15:0] page;
    logic busy;
    logic req_tog;
    logic done_seen;
    logic stale;
    logic pend_v;
    acc_t pend;
    acc_t cur;
    logic r_valid;
    logic [7:0] r_dst;
    logic [15:0] r_tid;
    logic [15:0] r_value;
  } link_st_t;

  // ==========================================================
  // Register domain state
  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_BUS = 2'b01
  } rstate_t;

  typedef struct packed {
    rstate_t state;
    logic req_seen;
    logic done_tog;
    logic we;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
  } reg_st_t;

  link_st_t l_q;
  link_st_t l_d;
  reg_st_t r_q;
  reg_st_t r_d;
  logic req_s;
  logic done_s;
  logic hit;
  logic in_user;
  logic [11:0] el_off;
  acc_t acc;

  // ==========================================================
  // Crossings: toggles only, words held stable behind them
  sync3 u_req_sync (
    .clk(ref_clk),
    .rstn(rstn),
    .d(l_q.req_tog),
    .q(req_s)
  );

  sync3 u_done_sync (
    .clk(link.link_clk),
    .rstn(rstn),
    .d(r_q.done_tog),
    .q(done_s)
  );

  // ==========================================================
  // Message decode
  always_comb
  begin
    // Filter on destination, access mode and slice size; source is free
    hit = link.m_valid && (link.m_dst == dev_la)
      && (link.m_mode == ACC_BYTE)
      && (link.m_slice == SLICE_2B);
    el_off = link.m_elem - USER_BASE;
    in_user = (link.m_elem >= USER_BASE) && (link.m_elem <= USER_LAST)
      && !link.m_elem[0];
    acc.addr = {l_q.page, el_off[LO_MSB:LO_LSB]};
    acc.data = link.m_value;
    acc.wr = (link.m_kind == MSG_CHANGE);
    acc.tid = link.m_value;
    acc.src = link.m_src;
  end

  // ==========================================================
  // Link domain next state
  always_comb
  begin
    l_d = l_q;
    l_d.r_valid = 1'b0;
    // Completion of the access in flight
    if (done_s != l_q.done_seen)
    begin
      l_d.done_seen = done_s;
      if (!l_q.cur.wr && !l_q.stale)
      begin
        l_d.r_valid = 1'b1;
        l_d.r_dst = l_q.cur.src;
        l_d.r_tid = l_q.cur.tid;
        l_d.r_value = r_q.rdata;
      end
      l_d.stale = 1'b0;
      if (l_q.pend_v)
      begin
        l_d.cur = l_q.pend;
        l_d.pend_v = 1'b0;
        l_d.req_tog = ~l_q.req_tog;
      end
      else
      begin
        l_d.busy = 1'b0;
      end
    end
    // New message on top of any completion
    if (hit && (link.m_kind == MSG_CHANGE) && (link.m_elem == PAGE_ELEM))
    begin
      l_d.page = link.m_value;
    end
    else if (hit && in_user)
    begin
      if (!l_d.busy)
      begin
        l_d.cur = acc;
        l_d.busy = 1'b1;
        l_d.req_tog = ~l_d.req_tog;
      end
      else
      begin
        // One waiting slot: a newer request replaces an older one
        l_d.pend = acc;
        l_d.pend_v = 1'b1;
        if (!acc.wr && !l_d.cur.wr)
        begin
          l_d.stale = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge link.link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      l_q <= '0;
      l_q.page <= PAGE_RST;
    end
    else
    begin
      l_q <= l_d;
    end
  end

  // ==========================================================
  // Register domain next state
  always_comb
  begin
    r_d = r_q;
    unique case (r_q.state)
      R_IDLE:
      begin
        if (req_s != r_q.req_seen)
        begin
          // Link holds cur steady until our done toggle returns
          r_d.req_seen = req_s;
          r_d.we = l_q.cur.wr;
          r_d.addr = l_q.cur.addr;
          r_d.wdata = l_q.cur.data;
          r_d.state = R_BUS;
        end
      end
      R_BUS:
      begin
        if (reg_ack)
        begin
          if (!r_q.we)
          begin
            r_d.rdata = reg_rdata;
          end
          r_d.done_tog = ~r_q.done_tog;
          r_d.state = R_IDLE;
        end
      end
      default:
      begin
        r_d.state = R_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      r_q <= '0;
      r_q.state <= R_IDLE;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_req = (r_q.state == R_BUS);
  assign reg_we = r_q.we;
  assign reg_addr = r_q.addr;
  assign reg_wdata = r_q.wdata;
  assign link.r_valid = l_q.r_valid;
  assign link.r_src = dev_la;
  assign link.r_dst = l_q.r_dst;
  assign link.r_tid = l_q.r_tid;
  assign link.r_value = l_q.r_value;

endmodule : dev_bridge
`default_nettype wire

// [rtl/mgr_end.sv]
`timescale 1ns/10ps
`default_nettype none
module mgr_end
  import regbridge_pkg::*;
(
  // Link side
  msg_link_if.mgr link,
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Target device address, static
  input wire logic [7:0] dev_la,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [23:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  // Read response
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [15:0] rsp_tid
);
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_PAGE = 2'b01,
    M_ACC = 2'b10,
    M_WAIT = 2'b11
  } mstate_t;

  typedef struct packed {
    logic busy;
    logic cmd_tog;
    logic done_seen;
    logic wr;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic [15:0] rsp_tid;
  } u_st_t;

  typedef struct packed {
    mstate_t state;
    logic cmd_seen;
    logic done_tog;
    logic [15:0] page;
    logic [15:0] tid;
    logic [15:0] rdata;
    logic m_valid;
    msg_kind_t m_kind;
    logic [11:0] m_elem;
    logic [15:0] m_value;
  } l_st_t;

  u_st_t u_q;
  u_st_t u_d;
  l_st_t l_q;
  l_st_t l_d;
  logic cmd_s;
  logic done_s;

  sync3 u_cmd_sync (
    .clk(link.link_clk),
    .rstn(rstn),
    .d(u_q.cmd_tog),
    .q(cmd_s)
  );

  sync3 u_done_sync (
    .clk(ref_clk),
    .rstn(rstn),
    .d(l_q.done_tog),
    .q(done_s)
  );

  // ==========================================================
  // User domain
  assign cmd_ready = !u_q.busy;

  always_comb
  begin
    u_d = u_q;
    u_d.rsp_valid = 1'b0;
    if (cmd_valid && !u_q.busy)
    begin
      u_d.busy = 1'b1;
      u_d.wr = cmd_write;
      u_d.addr = cmd_addr;
      u_d.wdata = cmd_wdata;
      u_d.cmd_tog = ~u_q.cmd_tog;
    end
    else if (done_s != u_q.done_seen)
    begin
      u_d.done_seen = done_s;
      u_d.busy = 1'b0;
      if (!u_q.wr)
      begin
        u_d.rsp_valid = 1'b1;
        u_d.rsp_data = l_q.rdata;
        u_d.rsp_tid = l_q.tid;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      u_q <= '0;
    end
    else
    begin
      u_q <= u_d;
    end
  end

  // ==========================================================
  // Link domain
  always_comb
  begin
    l_d = l_q;
    l_d.m_valid = 1'b0;
    unique case (l_q.state)
      M_IDLE:
      begin
        if (cmd_s != l_q.cmd_seen)
        begin
          l_d.cmd_seen = cmd_s;
          // Page message skipped while page unchanged
          l_d.state = (u_q.addr[23:8] == l_q.page) ? M_ACC : M_PAGE;
        end
      end
      M_PAGE:
      begin
        l_d.m_valid = 1'b1;
        l_d.m_kind = MSG_CHANGE;
        l_d.m_elem = PAGE_ELEM;
        l_d.m_value = u_q.addr[23:8];
        l_d.page = u_q.addr[23:8];
        l_d.state = M_ACC;
      end
      M_ACC:
      begin
        l_d.m_valid = 1'b1;
        l_d.m_kind = u_q.wr ? MSG_CHANGE : MSG_REQUEST;
        l_d.m_elem = USER_BASE + {3'h0, u_q.addr[7:0], 1'b0};
        if (u_q.wr)
        begin
          l_d.m_value = u_q.wdata;
          l_d.done_tog = ~l_q.done_tog;
          l_d.state = M_IDLE;
        end
        else
        begin
          l_d.tid = l_q.tid + 16'h0001;
          l_d.m_value = l_q.tid + 16'h0001;
          l_d.state = M_WAIT;
        end
      end
      M_WAIT:
      begin
        // No further request until the reply is in
        if (link.r_valid && (link.r_src == dev_la) && (link.r_tid == l_q.tid))
        begin
          l_d.rdata = link.r_value;
          l_d.done_tog = ~l_q.done_tog;
          l_d.state = M_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge link.link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      l_q <= '0;
      l_q.state <= M_IDLE;
      l_q.page <= PAGE_RST;
      l_q.tid <= TID_RST;
    end
    else
    begin
      l_q <= l_d;
    end
  end

  assign link.m_valid = l_q.m_valid;
  assign link.m_kind = l_q.m_kind;
  assign link.m_src = MGR_LA;
  assign link.m_dst = dev_la;
  assign link.m_mode = ACC_BYTE;
  assign link.m_elem = l_q.m_elem;
  assign link.m_slice = SLICE_2B;
  assign link.m_value = l_q.m_value;
  assign rsp_valid = u_q.rsp_valid;
  assign rsp_data = u_q.rsp_data;
  assign rsp_tid = u_q.rsp_tid;

endmodule : mgr_end
`default_nettype wire

// [rtl/dummy_unused_none.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [bench/regbridge_props.sv]
`timescale 1ns/10ps
`default_nettype none
module regbridge_props
  import regbridge_pkg::*;
(
  // Link clock and reset
  input wire logic link_clk,
  input wire logic rstn,
  // Messages
  input wire logic m_valid,
  input var msg_kind_t m_kind,
  input wire logic [7:0] m_src,
  input wire logic [7:0] m_dst,
  input wire logic m_mode,
  input wire logic [11:0] m_elem,
  input wire logic [2:0] m_slice,
  input wire logic [15:0] m_value,
  // Replies
  input wire logic r_valid,
  input wire logic [7:0] r_src,
  input wire logic [7:0] r_dst,
  input wire logic [15:0] r_tid
);
  logic pend_q;
  logic [15:0] tid_q;
  logic [7:0] src_q;
  logic [7:0] dst_q;
  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_q <= 1'b0;
      tid_q <= 16'h0;
      src_q <= 8'h0;
      dst_q <= 8'h0;
    end
    else if (m_valid && m_kind == MSG_REQUEST)
    begin
      pend_q <= 1'b1;
      tid_q <= m_value;
      src_q <= m_src;
      dst_q <= m_dst;
    end
    else if (r_valid)
      pend_q <= 1'b0;
  end
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (!rstn);
  sequence s_read;
    m_valid && m_kind == MSG_REQUEST;
  endsequence
  sequence s_access;
    m_valid && m_elem >= USER_BASE && m_elem <= USER_LAST && !m_elem[0];
  endsequence
  property p_mode; m_valid |-> m_mode == ACC_BYTE; endproperty
  property p_slice; m_valid |-> m_slice == SLICE_2B; endproperty
  property p_elem; m_valid && m_elem != PAGE_ELEM |-> s_access; endproperty
  property p_pgkind; m_valid && m_elem == PAGE_ELEM |-> m_kind == MSG_CHANGE; endproperty
  property p_page; m_valid && m_elem == PAGE_ELEM |=> s_access; endproperty
  property p_pace; s_read |-> !pend_q; endproperty
  // Bench answers the register bus within a few cycles
  property p_reply; s_read |-> ##[2:40] r_valid; endproperty
  property p_pulse; r_valid |=> !r_valid; endproperty
  property p_tid; r_valid |-> pend_q && r_tid == tid_q; endproperty
  property p_dst; r_valid |-> r_dst == src_q && r_src == dst_q; endproperty
  a_mode: assert property (p_mode) else $error("mode not byte");
  a_slice: assert property (p_slice) else $error("slice not two bytes");
  a_elem: assert property (p_elem) else $error("element outside window");
  a_pgkind: assert property (p_pgkind) else $error("page message not a change");
  a_page: assert property (p_page) else $error("page not followed by access");
  a_pace: assert property (p_pace) else $error("request before reply");
  a_reply: assert property (p_reply) else $error("no reply in time");
  a_pulse: assert property (p_pulse) else $error("reply longer than a cycle");
  a_tid: assert property (p_tid) else $error("reply id wrong");
  a_dst: assert property (p_dst) else $error("reply addresses wrong");
endmodule : regbridge_props
`default_nettype wire

// [bench/tb_slimbus_register_access_bridge.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_slimbus_register_access_bridge
  import regbridge_pkg::*;
;
  localparam logic [7:0] LA = 8'h2c;
  localparam logic [3:0] OK_MS = {ACC_BYTE, SLICE_2B};
  logic ref_clk = 1'b0, link_clk = 1'b0, rstn = 1'b0;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, rsp_valid;
  logic [23:0] cmd_addr = 24'h0, reg_addr, addr2, last_addr, la2;
  logic [15:0] cmd_wdata = 16'h0, rsp_data, rsp_tid, reg_wdata, wd2, last_wd, tid2, val2, lwd2;
  logic [15:0] reg_rdata = 16'h0;
  logic reg_req, reg_we, reg_ack = 1'b0, req2, we2, armed = 1'b1, lw2;
  logic [11:0] last_elem;
  logic [7:0] dst2;
  logic [15:0] mem [logic [23:0]];
  int errors = 0, checks = 0, npage = 0, nwr = 0, nreq2 = 0, nrep2 = 0;
  msg_link_if lk (.link_clk(link_clk));
  msg_link_if lk2 (.link_clk(link_clk));
  mgr_end mgr_end_i (.link(lk.mgr), .ref_clk(ref_clk), .rstn(rstn), .dev_la(LA), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_tid(rsp_tid));
  dev_bridge dev_bridge_i (.link(lk.dev), .dev_la(LA), .ref_clk(ref_clk), .rstn(rstn), .reg_req(reg_req),
    .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata));
  // Second device fed by the bench, so faulty messages can be sent
  dev_bridge dev_bridge_f_i (.link(lk2.dev), .dev_la(LA), .ref_clk(ref_clk), .rstn(rstn), .reg_req(req2),
    .reg_we(we2), .reg_addr(addr2), .reg_wdata(wd2), .reg_ack(req2), .reg_rdata(addr2[15:0]));
  regbridge_props regbridge_props_i (.link_clk(link_clk), .rstn(rstn), .m_valid(lk.m_valid),
    .m_kind(lk.m_kind), .m_src(lk.m_src), .m_dst(lk.m_dst), .m_mode(lk.m_mode), .m_elem(lk.m_elem),
    .m_slice(lk.m_slice), .m_value(lk.m_value), .r_valid(lk.r_valid), .r_src(lk.r_src),
    .r_dst(lk.r_dst), .r_tid(lk.r_tid));
  initial forever #20 ref_clk = ~ref_clk;
  initial
  begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  // ==========================================================
  // Register space and monitors
  always @(negedge ref_clk)
  begin
    reg_ack <= 1'b0;
    if (!reg_req)
      armed <= 1'b1;
    else if (armed)
    begin
      reg_ack <= 1'b1;
      armed <= 1'b0;
      last_addr <= reg_addr;
      last_wd <= reg_wdata;
      reg_rdata <= mem.exists(reg_addr) ? mem[reg_addr] : reg_addr[15:0];
      if (reg_we)
      begin
        mem[reg_addr] = reg_wdata;
        nwr++;
      end
    end
  end
  always @(posedge ref_clk)
    if (req2)
    begin
      nreq2++;
      lw2 = we2;
      lwd2 = wd2;
      la2 = addr2;
    end
  always @(posedge link_clk)
  begin
    if (lk.m_valid && lk.m_elem == PAGE_ELEM)
      npage++;
    else if (lk.m_valid)
      last_elem = lk.m_elem;
    if (lk2.r_valid)
    begin
      nrep2++;
      tid2 = lk2.r_tid;
      dst2 = lk2.r_dst;
      val2 = lk2.r_value;
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cmd(input logic w, input logic [23:0] a, input logic [15:0] d);
    int n;
    n = nwr;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    for (int i = 0; i < 2000 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    for (int i = 0; i < 2000 && (w ? nwr == n : rsp_valid !== 1'b1); i++) @(negedge ref_clk);
    chk("completion", w ? 24'(nwr - n) : {23'h0, rsp_valid}, 24'h1);
    // Register model updates land late in the same step; let them settle
    @(posedge ref_clk);
  endtask : cmd
  task automatic msg2(input msg_kind_t k, input logic [3:0] ms, input logic [11:0] e, input logic [15:0] v,
    input logic [7:0] d = LA, input logic [7:0] s = MGR_LA);
    @(negedge link_clk);
    lk2.m_valid = 1'b1;
    lk2.m_kind = k;
    lk2.m_src = s;
    lk2.m_dst = d;
    {lk2.m_mode, lk2.m_slice} = ms;
    lk2.m_elem = e;
    lk2.m_value = v;
  endtask : msg2
  task automatic idle2;
    @(negedge link_clk);
    lk2.m_valid = 1'b0;
    repeat (40) @(negedge link_clk);
  endtask : idle2
  task automatic conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // ==========================================================
  // Scenarios
  task automatic t_reset_page;
    cmd(1'b1, 24'h0000ab, 16'h1111);
    chk("page msgs", 24'(npage), 24'h0);
    chk("reg addr", last_addr, 24'h0000ab);
    chk("reg data", {8'h0, last_wd}, 24'h001111);
    $display("test reset_page done");
  endtask : t_reset_page
  task automatic t_write_read;
    cmd(1'b1, 24'h123456, 16'hbeef);
    chk("page msgs", 24'(npage), 24'h1);
    chk("reg addr", last_addr, 24'h123456);
    chk("element", {12'h0, last_elem}, {12'h0, USER_BASE + 12'h0ac});
    cmd(1'b0, 24'h123456, 16'h0);
    chk("read data", {8'h0, rsp_data}, 24'h00beef);
    chk("read id", {8'h0, rsp_tid}, 24'h000001);
    for (int i = 0; i < 2; i++)
    begin
      cmd(1'b1, {16'h1234, i ? 8'hff : 8'h00}, 16'h0f0f);
      chk("element", {12'h0, last_elem}, {12'h0, i ? USER_LAST : USER_BASE});
      chk("reg addr", last_addr, {16'h1234, i ? 8'hff : 8'h00});
    end
    chk("page msgs", 24'(npage), 24'h1);
    $display("test write_read done");
  endtask : t_write_read
  task automatic t_filter;
    msg2(MSG_REQUEST, OK_MS, USER_BASE, 16'h0005, LA ^ 8'h01);
    msg2(MSG_REQUEST, {1'b0, SLICE_2B}, USER_BASE, 16'h0005);
    msg2(MSG_REQUEST, {ACC_BYTE, 3'h2}, USER_BASE, 16'h0005);
    // Odd element and one past the window
    msg2(MSG_REQUEST, OK_MS, USER_BASE + 12'h001, 16'h0005);
    msg2(MSG_CHANGE, OK_MS, USER_LAST + 12'h002, 16'h0005);
    idle2();
    chk("ignored", 24'(nreq2 + nrep2), 24'h0);
    msg2(MSG_REQUEST, OK_MS, USER_BASE + 12'h068, 16'h0007, LA, 8'h12);
    idle2();
    chk("replies", 24'(nrep2), 24'h1);
    chk("reply dst", {16'h0, dst2}, 24'h000012);
    chk("reply id", {8'h0, tid2}, 24'h000007);
    chk("reply data", {8'h0, val2}, 24'h000034);
    msg2(MSG_CHANGE, OK_MS, USER_BASE + 12'h010, 16'h5a5a, LA, 8'h33);
    idle2();
    chk("write replies", 24'(nrep2), 24'h1);
    chk("write flag", {23'h0, lw2}, 24'h1);
    chk("write addr", la2, 24'h000008);
    chk("write data", {8'h0, lwd2}, 24'h005a5a);
    $display("test filter done");
  endtask : t_filter
  task automatic t_newest;
    msg2(MSG_CHANGE, OK_MS, PAGE_ELEM, 16'h00ab);
    msg2(MSG_REQUEST, OK_MS, USER_BASE + 12'h020, 16'h0008);
    msg2(MSG_REQUEST, OK_MS, USER_BASE + 12'h040, 16'h0009);
    idle2();
    chk("replies", 24'(nrep2), 24'h2);
    chk("reply id", {8'h0, tid2}, 24'h000009);
    chk("reply data", {8'h0, val2}, 24'h00ab20);
    $display("test newest done");
  endtask : t_newest
  initial
  begin
    lk2.m_valid = 1'b0;
    lk2.m_kind = MSG_CHANGE;
    lk2.m_src = 8'h0;
    lk2.m_dst = 8'h0;
    lk2.m_mode = 1'b0;
    lk2.m_elem = 12'h0;
    lk2.m_slice = 3'h0;
    lk2.m_value = 16'h0;
    // Held over link edges so both domains see it
    repeat (2) @(negedge link_clk);
    rstn = 1'b1;
    repeat (4) @(negedge link_clk);
    t_reset_page();
    t_write_read();
    t_filter();
    t_newest();
    conclude();
  end
  initial
  begin
    #400000;
    errors++;
    conclude();
  end
endmodule : tb_slimbus_register_access_bridge
`default_nettype wire
